//--- src/tmr_pkg.sv
// Constants, register map and state layout of the 16-bit timer block.
// Assumes a classic Wishbone slave with 5-bit byte addresses.
package tmr_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_COUNT = 5'h04;
  localparam logic [4:0] A_CMPA = 5'h08;
  localparam logic [4:0] A_CMPB = 5'h0c;
  localparam logic [4:0] A_CAPT = 5'h10;
  localparam logic [4:0] A_FLAG = 5'h14;
  localparam logic [4:0] A_PRESC = 5'h18;

  // ==========================================================
  // Field positions
  localparam int unsigned B_DIRA = 8;
  localparam int unsigned B_DIRB = 9;
  localparam int unsigned F_OVF = 0;
  localparam int unsigned F_CMPA = 1;
  localparam int unsigned F_CMPB = 2;
  localparam int unsigned F_CAP = 3;

  // ==========================================================
  // Waveform modes and output actions
  localparam logic [3:0] M_NORMAL = 4'h0;
  localparam logic [3:0] M_CTC_A = 4'h4;
  localparam logic [3:0] M_PWM8 = 4'h5;
  localparam logic [3:0] M_PWM9 = 4'h6;
  localparam logic [3:0] M_PWM10 = 4'h7;
  localparam logic [3:0] M_CTC_C = 4'hc;
  localparam logic [3:0] M_PWM_C = 4'he;
  localparam logic [3:0] M_PWM_A = 4'hf;
  localparam logic [1:0] OA_NONE = 2'h0;
  localparam logic [1:0] OA_TOGGLE = 2'h1;
  localparam logic [1:0] OA_CLEAR = 2'h2;
  localparam logic [1:0] OA_SET = 2'h3;

  // ==========================================================
  // Count limits and reset values
  localparam logic [15:0] C_MAX = 16'hffff;
  localparam logic [15:0] C_ZERO = 16'h0000;
  localparam logic [15:0] C_ONE = 16'h0001;
  localparam logic [15:0] TOP8 = 16'h00ff;
  localparam logic [15:0] TOP9 = 16'h01ff;
  localparam logic [15:0] TOP10 = 16'h03ff;
  localparam logic [15:0] PRESC_RST = 16'h0000;

  // ==========================================================
  // Whole state of the timer
  typedef struct packed {
    logic [15:0] count_value;
    logic [15:0] cmp_reg_a;
    logic [15:0] cmp_buf_a;
    logic [15:0] cmp_reg_b;
    logic [15:0] cmp_buf_b;
    logic [15:0] capture_reg;
    logic [15:0] presc_div;
    logic [15:0] presc_cnt;
    logic [3:0] waveform_mode_sel;
    logic [1:0] out_action_sel_a;
    logic [1:0] out_action_sel_b;
    logic pin_dir_out_a;
    logic pin_dir_out_b;
    logic [3:0] flags;
    logic cmp_out_a;
    logic cmp_out_b;
    logic pin_a;
    logic pin_b;
    logic tick;
    logic ack;
    logic [31:0] rdata;
  } tmr_state_t;

endpackage : tmr_pkg

//--- src/timer16_count_modes.sv
// Counting and waveform logic of a 16-bit timer with Wishbone registers.
// Assumes one 25 MHz clock, synchronous reset, same-domain bus master.
`timescale 1ns/1ps
module timer16_count_modes (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ovf_taken_i,
  output logic [3:0] flags_o,
  output logic cmp_pin_a_o,
  output logic cmp_pin_a_oe_o,
  output logic cmp_pin_b_o,
  output logic cmp_pin_b_oe_o
);

  // ==========================================================
  // Helpers
  function automatic logic is_pwm(input logic [3:0] m);
    return (m == tmr_pkg::M_PWM8) || (m == tmr_pkg::M_PWM9) ||
           (m == tmr_pkg::M_PWM10) || (m == tmr_pkg::M_PWM_C) ||
           (m == tmr_pkg::M_PWM_A);
  endfunction : is_pwm

  // Bits kept by a fixed-top mode; all ones otherwise
  function automatic logic [15:0] fix_mask(input logic [3:0] m);
    unique case (m)
      tmr_pkg::M_PWM8: return tmr_pkg::TOP8;
      tmr_pkg::M_PWM9: return tmr_pkg::TOP9;
      tmr_pkg::M_PWM10: return tmr_pkg::TOP10;
      default: return tmr_pkg::C_MAX;
    endcase
  endfunction : fix_mask

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  // Next internal output state for one channel
  function automatic logic oc_next(input logic [1:0] act,
                                   input logic pwm,
                                   input logic tgl_ok,
                                   input logic m,
                                   input logic t,
                                   input logic oc);
    logic r;
    r = oc;
    if (pwm) begin
      if (t && act[1]) r = act[0];
      if (m && act[1]) r = ~act[0];
      if (m && act == tmr_pkg::OA_TOGGLE && tgl_ok) r = ~oc;
    end else if (m) begin
      unique case (act)
        tmr_pkg::OA_TOGGLE: r = ~oc;
        tmr_pkg::OA_CLEAR: r = 1'b0;
        tmr_pkg::OA_SET: r = 1'b1;
        tmr_pkg::OA_NONE: r = oc;
      endcase
    end
    return r;
  endfunction : oc_next

  // ==========================================================
  // Decode
  tmr_pkg::tmr_state_t s_q;
  tmr_pkg::tmr_state_t s_d;
  logic req;
  logic wr;
  logic wr_cnt;
  logic wr_cmpa;
  logic pwm;
  logic clear_on_match_mode;
  logic [15:0] top;
  logic at_top;
  logic match_a;
  logic match_b;
  logic [15:0] wv;
  logic [15:0] mk;

  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = req & wb_we_i;
  assign wr_cnt = wr && (wb_adr_i == tmr_pkg::A_COUNT);
  assign wr_cmpa = wr && (wb_adr_i == tmr_pkg::A_CMPA);
  assign pwm = is_pwm(s_q.waveform_mode_sel);
  assign clear_on_match_mode = (s_q.waveform_mode_sel == tmr_pkg::M_CTC_A) ||
               (s_q.waveform_mode_sel == tmr_pkg::M_CTC_C);
  assign wv = wb_dat_i[15:0];
  assign mk = fix_mask(s_q.waveform_mode_sel);

  // Top from fixed values, capture or cmp A
  always_comb begin
    unique case (s_q.waveform_mode_sel)
      tmr_pkg::M_CTC_A,
      tmr_pkg::M_PWM_A: top = s_q.cmp_reg_a;
      tmr_pkg::M_CTC_C,
      tmr_pkg::M_PWM_C: top = s_q.capture_reg;
      tmr_pkg::M_PWM8: top = tmr_pkg::TOP8;
      tmr_pkg::M_PWM9: top = tmr_pkg::TOP9;
      tmr_pkg::M_PWM10: top = tmr_pkg::TOP10;
      default: top = tmr_pkg::C_MAX;
    endcase
  end

  // Exact equality only, so a top written below the count is missed
  assign at_top = (pwm || clear_on_match_mode) && (s_q.count_value == top);
  assign match_a = (s_q.count_value == s_q.cmp_reg_a);
  assign match_b = (s_q.count_value == s_q.cmp_reg_b);

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0] set;
    logic [3:0] clr;
    set = 4'h0;
    clr = 4'h0;
    s_d = s_q;
    s_d.ack = req;
    s_d.tick = (s_q.presc_cnt == s_q.presc_div);
    s_d.presc_cnt = s_d.tick ? tmr_pkg::C_ZERO
                             : s_q.presc_cnt + tmr_pkg::C_ONE;

    if (s_q.tick) begin
      if (at_top) begin
        s_d.count_value = tmr_pkg::C_ZERO;
      end else begin
        s_d.count_value = s_q.count_value + tmr_pkg::C_ONE;
      end
      if (pwm && at_top) begin
        s_d.cmp_reg_a = s_q.cmp_buf_a;
        s_d.cmp_reg_b = s_q.cmp_buf_b;
      end
      if (pwm) begin
        set[tmr_pkg::F_OVF] = at_top;
      end else begin
        set[tmr_pkg::F_OVF] = (s_q.count_value == tmr_pkg::C_MAX);
      end
      set[tmr_pkg::F_CMPA] = match_a;
      set[tmr_pkg::F_CMPB] = match_b;
      set[tmr_pkg::F_CAP] = at_top && top == s_q.capture_reg &&
                            (s_q.waveform_mode_sel == tmr_pkg::M_CTC_C ||
                             s_q.waveform_mode_sel == tmr_pkg::M_PWM_C);
      s_d.cmp_out_a = oc_next(s_q.out_action_sel_a, pwm,
                              s_q.waveform_mode_sel == tmr_pkg::M_PWM_A,
                              match_a, at_top, s_q.cmp_out_a);
      s_d.cmp_out_b = oc_next(s_q.out_action_sel_b, pwm, 1'b0,
                              match_b, at_top, s_q.cmp_out_b);
    end

    // Sticky until software clears it or the interrupt is taken
    clr[tmr_pkg::F_OVF] = ovf_taken_i;

    if (wr) begin
      case (wb_adr_i)
        tmr_pkg::A_CTRL: begin
          if (wb_sel_i[0]) begin
            s_d.waveform_mode_sel = wb_dat_i[3:0];
            s_d.out_action_sel_a = wb_dat_i[5:4];
            s_d.out_action_sel_b = wb_dat_i[7:6];
          end
          if (wb_sel_i[1]) begin
            s_d.pin_dir_out_a = wb_dat_i[tmr_pkg::B_DIRA];
            s_d.pin_dir_out_b = wb_dat_i[tmr_pkg::B_DIRB];
          end
        end
        // A bus write beats the tick in the same cycle
        tmr_pkg::A_COUNT: begin
          s_d.count_value = merge16(s_q.count_value, wv, wb_sel_i[1:0]);
        end
        tmr_pkg::A_CMPA: begin
          s_d.cmp_buf_a = merge16(s_q.cmp_buf_a, wv, wb_sel_i[1:0]) & mk;
          if (!pwm) s_d.cmp_reg_a = s_d.cmp_buf_a;
        end
        tmr_pkg::A_CMPB: begin
          s_d.cmp_buf_b = merge16(s_q.cmp_buf_b, wv, wb_sel_i[1:0]) & mk;
          if (!pwm) s_d.cmp_reg_b = s_d.cmp_buf_b;
        end
        tmr_pkg::A_CAPT: begin
          s_d.capture_reg = merge16(s_q.capture_reg, wv, wb_sel_i[1:0]);
        end
        tmr_pkg::A_FLAG: begin
          if (wb_sel_i[0]) clr = clr | wb_dat_i[3:0];
        end
        tmr_pkg::A_PRESC: begin
          s_d.presc_div = merge16(s_q.presc_div, wv, wb_sel_i[1:0]);
        end
        default: begin
        end
      endcase
    end

    // Set beats clear so no event is lost
    s_d.flags = (s_q.flags & ~clr) | set;

    if (req && !wb_we_i) begin
      case (wb_adr_i)
        tmr_pkg::A_CTRL: s_d.rdata = {22'h0, s_q.pin_dir_out_b,
                                      s_q.pin_dir_out_a, s_q.out_action_sel_b,
                                      s_q.out_action_sel_a, s_q.waveform_mode_sel};
        tmr_pkg::A_COUNT: s_d.rdata = {16'h0, s_q.count_value};
        tmr_pkg::A_CMPA: s_d.rdata = {16'h0, s_q.cmp_buf_a};
        tmr_pkg::A_CMPB: s_d.rdata = {16'h0, s_q.cmp_buf_b};
        tmr_pkg::A_CAPT: s_d.rdata = {16'h0, s_q.capture_reg};
        tmr_pkg::A_FLAG: s_d.rdata = {26'h0, s_q.cmp_out_b, s_q.cmp_out_a,
                                      s_q.flags};
        tmr_pkg::A_PRESC: s_d.rdata = {16'h0, s_q.presc_div};
        default: s_d.rdata = 32'h0;
      endcase
    end

    s_d.pin_a = s_d.pin_dir_out_a & s_d.cmp_out_a;
    s_d.pin_b = s_d.pin_dir_out_b & s_d.cmp_out_b;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.presc_div <= tmr_pkg::PRESC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign flags_o = s_q.flags;
  assign cmp_pin_a_o = s_q.pin_a;
  assign cmp_pin_b_o = s_q.pin_b;
  assign cmp_pin_a_oe_o = s_q.pin_dir_out_a;
  assign cmp_pin_b_oe_o = s_q.pin_dir_out_b;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wrap_tick;
    s_q.tick && !pwm && s_q.count_value == tmr_pkg::C_MAX && !wr_cnt;
  endsequence

  sequence s_pwm_top;
    s_q.tick && pwm && at_top && !wr_cnt && !wr_cmpa;
  endsequence

  a_norm_wrap: assert property (
    s_wrap_tick |=> s_q.count_value == tmr_pkg::C_ZERO && s_q.flags[tmr_pkg::F_OVF])
    else $error("counter wrap or overflow flag wrong");

  a_hold_no_tick: assert property (
    !s_q.tick && !wr_cnt |=> $stable(s_q.count_value))
    else $error("counter moved without tick");

  a_ctc_clear: assert property (
    s_q.tick && s_q.waveform_mode_sel == tmr_pkg::M_CTC_A && match_a && !wr_cnt
    |=> s_q.count_value == tmr_pkg::C_ZERO && s_q.flags[tmr_pkg::F_CMPA])
    else $error("clear on match failed");

  a_pwm_top: assert property (
    s_pwm_top |=> s_q.count_value == tmr_pkg::C_ZERO && s_q.flags[tmr_pkg::F_OVF])
    else $error("pwm top did not clear or flag");

  a_buf_load: assert property (
    s_pwm_top |=> s_q.cmp_reg_a == $past(s_q.cmp_buf_a))
    else $error("compare buffer not loaded at top");

  a_ctc_toggle: assert property (
    s_q.tick && clear_on_match_mode && match_a && s_q.out_action_sel_a == tmr_pkg::OA_TOGGLE
    |=> s_q.cmp_out_a != $past(s_q.cmp_out_a))
    else $error("toggle missing");

  a_pin_gate: assert property (
    !s_q.pin_dir_out_a |-> !s_q.pin_a)
    else $error("pin driven while direction is input");

  a_no_action: assert property (
    s_q.out_action_sel_a == tmr_pkg::OA_NONE && !wr |=> $stable(s_q.cmp_out_a))
    else $error("output changed with no action");

  a_fixed_mask: assert property (
    wr_cmpa && s_q.waveform_mode_sel == tmr_pkg::M_PWM8
    |=> s_q.cmp_buf_a[15:8] == 8'h00)
    else $error("fixed top did not mask write");

endmodule : timer16_count_modes

//--- tb/tb_top.sv
// Self-checking bench for the 16-bit timer counting and waveform block.
// Assumes one 25 MHz clock; the bench drives every port itself.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic ovf_taken_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] flags_o;
  logic cmp_pin_a_o, cmp_pin_a_oe_o, cmp_pin_b_o, cmp_pin_b_oe_o;
  int n_mismatch = 0;
  int check_count = 0;

  timer16_count_modes dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ovf_taken_i(ovf_taken_i), .flags_o(flags_o), .cmp_pin_a_o(cmp_pin_a_o),
    .cmp_pin_a_oe_o(cmp_pin_a_oe_o), .cmp_pin_b_o(cmp_pin_b_o),
    .cmp_pin_b_oe_o(cmp_pin_b_oe_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // Holds the request until ack is seen; a held request would be taken twice
  task automatic wb(input logic we, input logic [4:0] a, input logic [15:0] d,
                    output logic [31:0] r);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk({31'h0, wb_ack_o}, 32'h1, "bus answer missing");
  endtask : wb

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic wait_flag(input int b, output int n);
    n = 0;
    while (flags_o[b] !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, flags_o[b]}, 32'h1, "flag never set");
  endtask : wait_flag

  function automatic logic [15:0] ctrl(logic [3:0] m, logic [1:0] aa, logic [1:0] ab,
                                       logic da, logic db);
    return {6'h00, db, da, ab, aa, m};
  endfunction : ctrl

  // ==========================================================
  // Scenarios
  task automatic t_normal();
    int n;
    logic [31:0] r;
    wr(tmr_pkg::A_COUNT, 16'hfff0);
    wait_flag(tmr_pkg::F_OVF, n);
    // Divisor 0 ticks every cycle, so sixteen ticks take sixteen cycles
    chk({31'h0, n >= 15 && n <= 17}, 32'h1, "wrap timing");
    wb(1'b0, tmr_pkg::A_COUNT, 16'h0000, r);
    chk({31'h0, r < 32'h10}, 32'h1, "count after wrap");
    repeat (8) @(posedge clk_i);
    chk({31'h0, flags_o[0]}, 32'h1, "overflow not sticky");
    ovf_taken_i <= 1'b1;
    @(posedge clk_i);
    ovf_taken_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, flags_o[0]}, 32'h0, "overflow not cleared");
  endtask : t_normal

  task automatic t_ctc(input logic [3:0] m, input int fb);
    int n;
    logic p;
    logic [31:0] r;
    wr(tmr_pkg::A_CMPA, 16'h0005);
    wr(tmr_pkg::A_CAPT, 16'h0005);
    wr(tmr_pkg::A_COUNT, 16'h0000);
    wr(tmr_pkg::A_CTRL, ctrl(m, tmr_pkg::OA_TOGGLE, tmr_pkg::OA_NONE, 1'b1, 1'b0));
    wr(tmr_pkg::A_FLAG, 16'h000f);
    wait_flag(fb, n);
    p = cmp_pin_a_o;
    wr(tmr_pkg::A_FLAG, 16'h000f);
    wait_flag(fb, n);
    if (m == tmr_pkg::M_CTC_A) begin
      chk({31'h0, cmp_pin_a_o}, {31'h0, ~p}, "no toggle on match");
    end
    wb(1'b0, tmr_pkg::A_COUNT, 16'h0000, r);
    chk({31'h0, r <= 32'h5}, 32'h1, "count above top");
    chk({31'h0, flags_o[0]}, 32'h0, "overflow without wrap");
  endtask : t_ctc

  task automatic t_miss();
    logic [31:0] r;
    wr(tmr_pkg::A_COUNT, 16'h0100);
    wr(tmr_pkg::A_FLAG, 16'h000f);
    repeat (60) @(posedge clk_i);
    chk({31'h0, flags_o[1]}, 32'h0, "match below count taken");
    wb(1'b0, tmr_pkg::A_COUNT, 16'h0000, r);
    chk({31'h0, r > 32'h100}, 32'h1, "counter did not run on");
  endtask : t_miss

  task automatic t_pin();
    logic p;
    wr(tmr_pkg::A_COUNT, 16'h0000);
    wr(tmr_pkg::A_CTRL, ctrl(tmr_pkg::M_CTC_A, tmr_pkg::OA_TOGGLE, 2'h0, 1'b0, 1'b0));
    repeat (30) @(posedge clk_i);
    chk({30'h0, cmp_pin_a_o, cmp_pin_a_oe_o}, 32'h0, "pin shown as input");
    wr(tmr_pkg::A_CTRL, ctrl(tmr_pkg::M_CTC_A, tmr_pkg::OA_NONE, 2'h0, 1'b1, 1'b0));
    @(posedge clk_i);
    p = cmp_pin_a_o;
    repeat (40) @(posedge clk_i);
    chk({30'h0, cmp_pin_a_o, cmp_pin_a_oe_o}, {30'h0, p, 1'b1}, "idle action moved");
  endtask : t_pin

  task automatic t_pwm(input logic [1:0] a, input int exp);
    int n;
    int hi = 0;
    logic [31:0] r;
    // Top kept at or above every compare value
    wr(tmr_pkg::A_CAPT, 16'h0009);
    wr(tmr_pkg::A_CMPB, 16'h0003);
    wr(tmr_pkg::A_COUNT, 16'h0000);
    wr(tmr_pkg::A_CTRL, ctrl(tmr_pkg::M_PWM_C, tmr_pkg::OA_NONE, a, 1'b0, 1'b1));
    wr(tmr_pkg::A_FLAG, 16'h000f);
    wait_flag(tmr_pkg::F_OVF, n);
    chk({31'h0, flags_o[3]}, 32'h1, "top flag missing");
    // Twenty whole periods of ten cycles, so the phase does not matter
    repeat (200) begin
      @(posedge clk_i);
      hi += cmp_pin_b_o;
    end
    chk(32'(hi), 32'(exp), "duty cycle");
    chk({31'h0, flags_o[2]}, 32'h1, "channel flag missing");
    wb(1'b0, tmr_pkg::A_COUNT, 16'h0000, r);
    chk({31'h0, r <= 32'h9}, 32'h1, "count above top");
  endtask : t_pwm

  task automatic t_mask();
    logic [3:0] ms[3] = '{tmr_pkg::M_PWM8, tmr_pkg::M_PWM9, tmr_pkg::M_PWM10};
    logic [15:0] ts[3] = '{tmr_pkg::TOP8, tmr_pkg::TOP9, tmr_pkg::TOP10};
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      wr(tmr_pkg::A_CTRL, ctrl(ms[i], 2'h0, 2'h0, 1'b0, 1'b0));
      wr(tmr_pkg::A_CMPB, 16'hffff);
      wb(1'b0, tmr_pkg::A_CMPB, 16'h0000, r);
      chk(r, {16'h0000, ts[i]}, "compare not masked");
    end
  endtask : t_mask

  // ==========================================================
  // Verdict, sequence and watchdog
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, flags_o}, 32'h0, "flags after reset");
    chk({30'h0, cmp_pin_a_o, cmp_pin_b_o}, 32'h0, "pins after reset");
    t_normal();
    t_ctc(tmr_pkg::M_CTC_A, tmr_pkg::F_CMPA);
    t_ctc(tmr_pkg::M_CTC_C, tmr_pkg::F_CAP);
    t_miss();
    t_pin();
    t_pwm(tmr_pkg::OA_CLEAR, 120);
    t_pwm(tmr_pkg::OA_SET, 80);
    t_mask();
    give_verdict();
  end

  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_top
